// [logic/smt_master.sv]
// Permanent bus master timing: clocks, ticks, hang timeout, status and strobes
module smt_master #(
	parameter int unsigned TICK50_CYC = smt_pkg::TICK50_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Backplane and panel link
	smt_bus_if.master bus,
	// Processor cycle request
	input wire logic cyc_req,
	input wire smt_pkg::smt_kind_t cyc_kind,
	input wire logic cyc_wr_block,
	output logic cyc_done,
	output logic cpu_clk,
	// Jumper options
	input wire logic alt_slow,
	input wire logic [1:0] stval_sel,
	input wire logic tick5_jumper,
	// Timeout inputs and ROM control
	input wire logic int_pending,
	input wire logic int_enabled,
	input wire logic supervisor,
	input wire logic panel_wait,
	input wire logic rom_clear,
	output logic rom_enable,
	// Interrupt sources
	output logic int3_req,
	output logic int5_req,
	output logic tick_1,
	output logic nmi_req,
	output logic bus_int_req,
	// Front panel data path
	input wire logic [7:0] panel_tx,
	output logic [7:0] panel_rx,
	output logic panel_override
);
	import smt_pkg::*;

	typedef struct packed {
		logic [4:0] clk_cnt;
		logic bus_clock;
		logic [3:0] phi_cnt;
		logic phi;
		logic cpu_ck;
		logic [20:0] t50_cnt;
		logic [5:0] half_cnt;
		logic sq1;
		logic tick50;
		logic tick1;
		logic int5;
		logic [1:0] hang_cnt;
		logic nmi;
		logic rom_en;
		logic [1:0] rdy_s;
		logic [1:0] xrdy_s;
		logic [1:0] hold_s;
		logic [1:0] int_s;
		logic [1:0] nmi_s;
		logic [1:0] ddsb_s;
		logic nmi_prev;
		logic int_req;
		smt_bstate_t st;
		smt_kind_t kind;
		logic blk;
		smt_status_t status;
		logic psync;
		logic pstval_n;
		logic pdbin;
		logic pwr_n;
		logic phlda;
		logic done;
		logic [7:0] rx;
		logic ovr;
		logic [7:0] tx;
	} smt_mstate_t;

	smt_mstate_t s_reg;
	smt_mstate_t s_next;

	function automatic logic is_read(input smt_kind_t k);
		return k == SMT_FETCH || k == SMT_MEM_RD || k == SMT_HALT || k == SMT_IO_IN;
	endfunction : is_read

	function automatic logic is_write(input smt_kind_t k);
		return k == SMT_MEM_WR || k == SMT_IO_OUT;
	endfunction : is_write

	function automatic smt_status_t kind_status(input smt_kind_t k);
		smt_status_t r;
		r = STATUS_IDLE;
		r.m1 = (k == SMT_FETCH);
		r.memr = (k == SMT_FETCH || k == SMT_MEM_RD || k == SMT_HALT);
		r.hlta = (k == SMT_HALT);
		r.inp = (k == SMT_IO_IN);
		r.out = (k == SMT_IO_OUT);
		r.wo_n = is_read(k);
		return r;
	endfunction : kind_status

	logic [3:0] phi_half;
	logic phi_flip;
	logic phi_rise;
	logic t50_wrap;
	logic half_wrap;
	logic hang;
	logic bus_ready;
	logic [3:0] stval_off;

	always_comb begin
		s_next = s_reg;
		phi_half = alt_slow ? PHI_HALF_SLOW : PHI_HALF_FAST;
		phi_flip = (s_reg.phi_cnt == phi_half - 4'h1);
		phi_rise = phi_flip && !s_reg.phi;
		t50_wrap = (s_reg.t50_cnt == 21'(TICK50_CYC - 1));
		half_wrap = t50_wrap && (s_reg.half_cnt == TICKS_PER_HALF_SEC - 6'h1);
		bus_ready = s_reg.rdy_s[1] && s_reg.xrdy_s[1];
		stval_off = (stval_sel == 2'h0) ? 4'h0 : (stval_sel == 2'h1) ? STVAL_STEP : 4'(2 * STVAL_STEP);
		// Bus CLOCK runs from its own divider, unrelated to PHI
		if (s_reg.clk_cnt == CLOCK_HALF - 5'h1) begin
			s_next.clk_cnt = 5'h0;
			s_next.bus_clock = !s_reg.bus_clock;
		end else begin
			s_next.clk_cnt = s_reg.clk_cnt + 5'h1;
		end
		if (phi_flip) begin
			s_next.phi_cnt = 4'h0;
			s_next.phi = !s_reg.phi;
		end else begin
			s_next.phi_cnt = s_reg.phi_cnt + 4'h1;
		end
		s_next.cpu_ck = !s_next.phi;
		// Both ticks from one chain so they never drift apart
		s_next.t50_cnt = t50_wrap ? 21'h0 : s_reg.t50_cnt + 21'h1;
		s_next.tick50 = t50_wrap;
		s_next.tick1 = 1'b0;
		if (t50_wrap) begin
			s_next.half_cnt = half_wrap ? 6'h0 : s_reg.half_cnt + 6'h1;
		end
		if (half_wrap) begin
			s_next.sq1 = !s_reg.sq1;
			s_next.tick1 = !s_reg.sq1;
		end
		s_next.int5 = s_next.tick1 && tick5_jumper;
		// Hang timeout counts half-second boundaries so the delay lands in 0.5 to 1 s
		hang = int_pending && !int_enabled && !panel_wait && !s_reg.phlda && !supervisor;
		s_next.nmi = 1'b0;
		if (!hang) begin
			s_next.hang_cnt = 2'h0;
		end else if (half_wrap) begin
			if (s_reg.hang_cnt == HANG_HALF_SECS - 2'h1) begin
				s_next.hang_cnt = 2'h0;
				s_next.nmi = 1'b1;
			end else begin
				s_next.hang_cnt = s_reg.hang_cnt + 2'h1;
			end
		end
		// Control input pins pass two flip-flops before use; panel data takes one
		s_next.rdy_s = {s_reg.rdy_s[0], bus.rdy};
		s_next.xrdy_s = {s_reg.xrdy_s[0], bus.xrdy};
		s_next.hold_s = {s_reg.hold_s[0], bus.hold_n};
		s_next.int_s = {s_reg.int_s[0], bus.int_n};
		s_next.nmi_s = {s_reg.nmi_s[0], bus.nmi_n};
		s_next.ddsb_s = {s_reg.ddsb_s[0], bus.fp_ddsb_n};
		s_next.nmi_prev = s_reg.nmi_s[1];
		s_next.int_req = !s_reg.int_s[1];
		if (s_reg.nmi_prev && !s_reg.nmi_s[1]) begin
			s_next.nmi = 1'b1;
		end
		// Set wins over a clear arriving in the same cycle
		if (s_next.nmi) begin
			s_next.rom_en = 1'b1;
		end else if (rom_clear) begin
			s_next.rom_en = 1'b0;
		end
		// Panel link: data-in disable hands the read path to the panel
		s_next.ovr = !s_reg.ddsb_s[1];
		s_next.rx = bus.fp_to_master;
		s_next.tx = panel_tx;
		s_next.done = 1'b0;
		unique case (s_reg.st)
			SMT_IDLE: begin
				if (phi_rise) begin
					if (!s_reg.hold_s[1]) begin
						s_next.phlda = 1'b1;
						s_next.st = SMT_GRANT;
					end else if (cyc_req) begin
						s_next.kind = cyc_kind;
						s_next.blk = cyc_wr_block;
						s_next.status = kind_status(cyc_kind);
						if (cyc_kind == SMT_INTA) begin
							s_next.done = 1'b1;
						end else if (cyc_kind == SMT_IO_IN || cyc_kind == SMT_IO_OUT) begin
							s_next.st = SMT_IO_DLY;
						end else begin
							s_next.psync = 1'b1;
							s_next.st = SMT_SYNC;
						end
					end
				end
			end
			SMT_IO_DLY: begin
				if (phi_rise) begin
					s_next.psync = 1'b1;
					s_next.st = SMT_SYNC;
				end
			end
			SMT_SYNC: begin
				s_next.pstval_n = !(s_next.phi_cnt >= stval_off);
				if (phi_rise) begin
					s_next.psync = 1'b0;
					s_next.pstval_n = 1'b1;
					s_next.pdbin = is_read(s_reg.kind);
					s_next.pwr_n = !(is_write(s_reg.kind) && !s_reg.blk);
					s_next.st = SMT_STROBE;
				end
			end
			SMT_STROBE: begin
				if (phi_rise && bus_ready) begin
					s_next.pdbin = 1'b0;
					s_next.pwr_n = 1'b1;
					s_next.status.wo_n = 1'b0;
					s_next.done = 1'b1;
					s_next.st = SMT_IDLE;
				end
			end
			SMT_GRANT: begin
				if (phi_rise && s_reg.hold_s[1]) begin
					s_next.phlda = 1'b0;
					s_next.st = SMT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.cpu_ck <= 1'b1;
			s_reg.rom_en <= ROM_EN_RESET;
			s_reg.rdy_s <= 2'h3;
			s_reg.xrdy_s <= 2'h3;
			s_reg.hold_s <= 2'h3;
			s_reg.int_s <= 2'h3;
			s_reg.nmi_s <= 2'h3;
			s_reg.ddsb_s <= 2'h3;
			s_reg.nmi_prev <= 1'b1;
			s_reg.st <= SMT_IDLE;
			s_reg.kind <= SMT_FETCH;
			s_reg.status <= STATUS_IDLE;
			s_reg.pstval_n <= 1'b1;
			s_reg.pwr_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus.bus_clock = s_reg.bus_clock;
	assign bus.phi = s_reg.phi;
	assign bus.status = s_reg.status;
	assign bus.psync = s_reg.psync;
	assign bus.pstval_n = s_reg.pstval_n;
	assign bus.pdbin = s_reg.pdbin;
	assign bus.pwr_n = s_reg.pwr_n;
	assign bus.phlda = s_reg.phlda;
	assign bus.par_en_n = s_reg.status.wo_n;
	assign bus.fp_to_panel = s_reg.tx;
	assign cyc_done = s_reg.done;
	assign cpu_clk = s_reg.cpu_ck;
	assign rom_enable = s_reg.rom_en;
	assign int3_req = s_reg.tick50;
	assign int5_req = s_reg.int5;
	assign tick_1 = s_reg.tick1;
	assign nmi_req = s_reg.nmi;
	assign bus_int_req = s_reg.int_req;
	assign panel_rx = s_reg.rx;
	assign panel_override = s_reg.ovr;
endmodule : smt_master

// [logic/smt_pkg.sv]
// Shared constants and types for the bus master timing block and its bus partners
package smt_pkg;
	localparam int unsigned SYS_HZ = 100_000_000;
	localparam int unsigned CLOCK_HZ = 2_000_000;
	localparam int unsigned XTAL_FAST_HZ = 12_000_000;
	localparam int unsigned XTAL_SLOW_HZ = 8_000_000;
	localparam int unsigned PHI_FAST_HZ = XTAL_FAST_HZ / 2;
	localparam int unsigned PHI_SLOW_HZ = XTAL_SLOW_HZ / 2;
	localparam int unsigned TICK_FAST_HZ = 50;
	localparam int unsigned TICK_SLOW_HZ = 1;
	// Half periods in ref_clk cycles; PHI rounds down to the nearest whole cycle
	localparam logic [4:0] CLOCK_HALF = 5'(SYS_HZ / (2 * CLOCK_HZ));
	localparam logic [3:0] PHI_HALF_FAST = 4'(SYS_HZ / (2 * PHI_FAST_HZ));
	localparam logic [3:0] PHI_HALF_SLOW = 4'(SYS_HZ / (2 * PHI_SLOW_HZ));
	localparam int unsigned TICK50_CYCLES = SYS_HZ / TICK_FAST_HZ;
	localparam logic [5:0] TICKS_PER_HALF_SEC = 6'(TICK_FAST_HZ / (2 * TICK_SLOW_HZ));
	localparam logic [1:0] HANG_HALF_SECS = 2'h2;
	localparam logic [3:0] STVAL_STEP = 4'h2;
	localparam logic ROM_EN_RESET = 1'b1;

	typedef enum logic [2:0] {
		SMT_FETCH,
		SMT_MEM_RD,
		SMT_MEM_WR,
		SMT_IO_IN,
		SMT_IO_OUT,
		SMT_INTA,
		SMT_HALT
	} smt_kind_t;

	typedef enum logic [2:0] {
		SMT_IDLE,
		SMT_IO_DLY,
		SMT_SYNC,
		SMT_STROBE,
		SMT_GRANT
	} smt_bstate_t;

	typedef struct packed {
		logic m1;
		logic memr;
		logic hlta;
		logic inp;
		logic out;
		logic wo_n;
		logic inta;
		logic sxtrq_n;
	} smt_status_t;

	localparam smt_status_t STATUS_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
endpackage : smt_pkg

// [logic/smt_bus_if.sv]
// Backplane and front panel lines shared by the master and its bus partners
interface smt_bus_if (
	input wire logic ref_clk
);
	import smt_pkg::*;
	logic bus_clock;
	logic phi;
	smt_status_t status;
	logic psync;
	logic pstval_n;
	logic pdbin;
	logic pwr_n;
	logic phlda;
	logic par_en_n;
	logic rdy;
	logic xrdy;
	logic hold_n;
	logic int_n;
	logic nmi_n;
	logic [7:0] fp_to_master;
	logic [7:0] fp_to_panel;
	logic fp_ddsb_n;

	modport master (
		output bus_clock, phi, status, psync, pstval_n, pdbin, pwr_n, phlda, par_en_n,
		output fp_to_panel,
		input rdy, xrdy, hold_n, int_n, nmi_n, fp_to_master, fp_ddsb_n
	);
	modport partner (
		input bus_clock, phi, status, psync, pstval_n, pdbin, pwr_n, phlda, par_en_n,
		input fp_to_panel,
		output rdy, xrdy, hold_n, int_n, nmi_n, fp_to_master, fp_ddsb_n
	);
endinterface : smt_bus_if

// [logic/smt_partner.sv]
// Bus partner end: slave ready, front panel stop and step, DMA hold, interrupt lines
module smt_partner (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Backplane and panel link
	smt_bus_if.partner bus,
	// Slave and panel controls
	input wire logic slave_wait,
	input wire logic panel_stop,
	input wire logic panel_step,
	input wire logic panel_ddsb,
	input wire logic [7:0] panel_data,
	// Requests toward the master
	input wire logic dma_req,
	input wire logic int_req,
	input wire logic nmi_req,
	// Observed bus activity
	output logic cyc_seen,
	output logic [7:0] seen_status,
	output logic rd_seen,
	output logic wr_seen,
	output logic dma_owner,
	output logic [7:0] panel_seen
);
	import smt_pkg::*;

	typedef struct packed {
		logic [1:0] sync_s;
		logic [1:0] dbin_s;
		logic [1:0] wr_s;
		logic [1:0] hlda_s;
		logic sync_prev;
		logic dbin_prev;
		logic wr_prev;
		logic step_arm;
		logic cyc;
		logic rd;
		logic wr;
		logic [7:0] stat;
		logic owner;
		logic rdy;
		logic xrdy;
		logic hold_n;
		logic int_n;
		logic nmi_n;
		logic ddsb_n;
		logic [7:0] fp;
		logic [7:0] seen;
	} smt_pstate_t;

	smt_pstate_t p_reg;
	smt_pstate_t p_next;
	logic strobe_end;

	always_comb begin
		p_next = p_reg;
		p_next.sync_s = {p_reg.sync_s[0], bus.psync};
		p_next.dbin_s = {p_reg.dbin_s[0], bus.pdbin};
		p_next.wr_s = {p_reg.wr_s[0], !bus.pwr_n};
		p_next.hlda_s = {p_reg.hlda_s[0], bus.phlda};
		p_next.sync_prev = p_reg.sync_s[1];
		p_next.dbin_prev = p_reg.dbin_s[1];
		p_next.wr_prev = p_reg.wr_s[1];
		p_next.cyc = p_reg.sync_s[1] && !p_reg.sync_prev;
		p_next.rd = p_reg.dbin_s[1] && !p_reg.dbin_prev;
		p_next.wr = p_reg.wr_s[1] && !p_reg.wr_prev;
		if (p_next.cyc) begin
			p_next.stat = bus.status;
			p_next.seen = bus.fp_to_panel;
		end
		p_next.owner = p_reg.hlda_s[1];
		strobe_end = (p_reg.dbin_prev && !p_reg.dbin_s[1]) || (p_reg.wr_prev && !p_reg.wr_s[1]);
		// A step lets one cycle with a read or write strobe finish (a blocked write does not use it up); a new step press wins over the release
		if (panel_step) begin
			p_next.step_arm = 1'b1;
		end else if (strobe_end) begin
			p_next.step_arm = 1'b0;
		end
		p_next.rdy = !slave_wait;
		p_next.xrdy = !panel_stop || p_next.step_arm;
		p_next.hold_n = !dma_req;
		p_next.int_n = !int_req;
		p_next.nmi_n = !nmi_req;
		p_next.ddsb_n = !panel_ddsb;
		p_next.fp = panel_data;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			p_reg <= '0;
			p_reg.rdy <= 1'b1;
			p_reg.xrdy <= 1'b1;
			p_reg.hold_n <= 1'b1;
			p_reg.int_n <= 1'b1;
			p_reg.nmi_n <= 1'b1;
			p_reg.ddsb_n <= 1'b1;
		end else begin
			p_reg <= p_next;
		end
	end

	assign bus.rdy = p_reg.rdy;
	assign bus.xrdy = p_reg.xrdy;
	assign bus.hold_n = p_reg.hold_n;
	assign bus.int_n = p_reg.int_n;
	assign bus.nmi_n = p_reg.nmi_n;
	assign bus.fp_ddsb_n = p_reg.ddsb_n;
	assign bus.fp_to_master = p_reg.fp;
	assign cyc_seen = p_reg.cyc;
	assign seen_status = p_reg.stat;
	assign rd_seen = p_reg.rd;
	assign wr_seen = p_reg.wr;
	assign dma_owner = p_reg.owner;
	assign panel_seen = p_reg.seen;
endmodule : smt_partner

// [test/smt_sva.sv]
// Interface timing checks between the bus master and its partner end
module smt_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Master outputs
	input wire logic bus_clock,
	input wire logic phi,
	input wire smt_pkg::smt_status_t status,
	input wire logic psync,
	input wire logic pstval_n,
	input wire logic pdbin,
	input wire logic pwr_n,
	input wire logic phlda,
	input wire logic par_en_n,
	// Partner outputs
	input wire logic rdy,
	input wire logic xrdy,
	// Board jumpers, changed only while reset is held
	input wire logic alt_slow,
	input wire logic [1:0] stval_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	import smt_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Two sync flops plus the registered strobe put the sampled ready three cycles back
	sequence ready_seen;
		$past(rdy, 3) && $past(xrdy, 3);
	endsequence
	sequence sync_period;
		psync [*8] ##1 psync [*8];
	endsequence
	sequence sync_slow_period;
		psync [*8] ##1 psync [*8] ##1 psync [*8];
	endsequence
	clock_half_a: assert property ($rose(bus_clock) |-> ##25 $fell(bus_clock))
		else $error("bus clock high phase wrong");
	phi_half_a: assert property ($rose(phi) && !alt_slow |-> ##8 $fell(phi))
		else $error("phi high phase wrong");
	phi_slow_a: assert property ($rose(phi) && alt_slow |-> ##12 $fell(phi))
		else $error("slow phi high phase wrong");
	status_fixed_a: assert property (status.inta == 1'b0 && status.sxtrq_n == 1'b1)
		else $error("acknowledge or wide request line active");
	parity_en_a: assert property (par_en_n == status.wo_n)
		else $error("parity enable differs from write status");
	stval_sync_a: assert property (!pstval_n |-> psync)
		else $error("status valid outside sync");
	sync_len_a: assert property ($rose(psync) && !alt_slow |-> sync_period ##1 !psync)
		else $error("sync not one phi period");
	sync_slow_a: assert property ($rose(psync) && alt_slow |-> sync_slow_period ##1 !psync)
		else $error("slow sync not one phi period");
	stval_early_a: assert property ($rose(psync) && stval_sel == 2'h0 |-> pstval_n ##1 !pstval_n)
		else $error("early status valid timing wrong");
	stval_mid_a: assert property ($rose(psync) && stval_sel == 2'h1 |-> pstval_n [*2] ##1 !pstval_n)
		else $error("middle status valid timing wrong");
	stval_late_a: assert property ($rose(psync) && stval_sel[1] |-> pstval_n [*4] ##1 !pstval_n)
		else $error("late status valid timing wrong");
	status_hold_a: assert property (psync && $past(psync) |-> $stable(status))
		else $error("status moved during sync");
	read_dir_a: assert property (pdbin |-> status.wo_n && pwr_n)
		else $error("read strobe on a write cycle");
	write_dir_a: assert property (!pwr_n |-> !status.wo_n)
		else $error("write strobe on a read cycle");
	read_ready_a: assert property ($fell(pdbin) |-> ready_seen)
		else $error("read ended while not ready");
	write_ready_a: assert property ($rose(pwr_n) |-> ready_seen)
		else $error("write ended while not ready");
	grant_quiet_a: assert property (phlda |-> !psync && !pdbin && pwr_n)
		else $error("bus cycle while hold granted");
endmodule : smt_sva

// [test/s100_master_timing_bench.sv]
// Self-checking bench: master and partner ends joined across the backplane interface
module s100_master_timing_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import smt_pkg::*;
	localparam int T50 = 40;
	localparam logic [7:0] EXP [7] = '{8'hC5, 8'h45, 8'h01, 8'h15, 8'h09, 8'h00, 8'h25};
	localparam logic [7:0] MSK [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h3F};
	localparam logic [6:0] RD = 7'b0001011;
	localparam logic [6:0] WR = 7'b0010100;
	localparam logic [6:0] SY = 7'b1011111;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	smt_kind_t cyc_kind = SMT_FETCH;
	logic cyc_req = 1'b0, cyc_wr_block = 1'b0, tick5_jumper = 1'b0, rom_clear = 1'b0;
	logic int_pending = 1'b0, int_enabled = 1'b0, supervisor = 1'b0, panel_wait = 1'b0;
	logic slave_wait = 1'b0, panel_stop = 1'b0, panel_step = 1'b0, panel_ddsb = 1'b1;
	logic dma_req = 1'b0, int_req = 1'b0, pin_nmi = 1'b0;
	logic [7:0] panel_tx = 8'hA5, panel_data = 8'h3C;
	logic alt_slow = 1'b0;
	logic [1:0] stval_sel = 2'h1;
	logic cyc_done, cpu_clk, rom_enable, int3_req, int5_req, tick_1, nmi_req, bus_int_req;
	logic panel_override, cyc_seen, rd_seen, wr_seen, dma_owner;
	logic [7:0] panel_rx, seen_status, panel_seen;
	int err_total = 0;
	int tests_run = 0;
	smt_bus_if bus_i (.ref_clk(ref_clk));
	smt_master #(.TICK50_CYC(T50)) smt_master_inst (.ref_clk, .rst_n, .bus(bus_i), .cyc_req,
		.cyc_kind, .cyc_wr_block, .cyc_done, .cpu_clk, .alt_slow, .stval_sel,
		.tick5_jumper, .int_pending, .int_enabled, .supervisor, .panel_wait, .rom_clear,
		.rom_enable, .int3_req, .int5_req, .tick_1, .nmi_req, .bus_int_req, .panel_tx,
		.panel_rx, .panel_override);
	smt_partner smt_partner_inst (.ref_clk, .rst_n, .bus(bus_i), .slave_wait, .panel_stop,
		.panel_step, .panel_ddsb, .panel_data, .dma_req, .int_req, .nmi_req(pin_nmi),
		.cyc_seen, .seen_status, .rd_seen, .wr_seen, .dma_owner, .panel_seen);
	smt_sva smt_sva_inst (.ref_clk, .rst_n, .bus_clock(bus_i.bus_clock), .phi(bus_i.phi),
		.status(bus_i.status), .psync(bus_i.psync), .pstval_n(bus_i.pstval_n),
		.pdbin(bus_i.pdbin), .pwr_n(bus_i.pwr_n), .phlda(bus_i.phlda),
		.par_en_n(bus_i.par_en_n), .rdy(bus_i.rdy), .xrdy(bus_i.xrdy), .alt_slow,
		.stval_sel);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte
	function automatic logic sig(input int k);
		case (k)
			1: return nmi_req;
			2: return dma_owner;
			3: return tick_1;
			4: return int3_req;
			default: return bus_int_req;
		endcase
	endfunction : sig
	// Counts falling edges up to and including the one where the flag is seen
	task automatic wait_ev(input int k, input int lim, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (sig(k) !== 1'b1 && n <= lim);
	endtask : wait_ev
	task automatic need(input int k, input int lim, output int n);
		wait_ev(k, lim, n);
		if (n > lim) begin
			err_total++;
			end_of_test();
		end
	endtask : need
	task automatic run_cyc(input smt_kind_t k, input logic blk, input int lim,
		output int n, output int rd, output int wr, output int sy);
		{n, rd, wr, sy} = '0;
		cyc_kind = k;
		cyc_wr_block = blk;
		cyc_req = 1'b1;
		do begin
			@(negedge ref_clk);
			n++;
			rd += int'(rd_seen);
			wr += int'(wr_seen);
			sy += int'(cyc_seen);
			chk_bit(cpu_clk, ~bus_i.phi);
		end while (cyc_done !== 1'b1 && n < lim);
		cyc_req = 1'b0;
		if (cyc_done !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		// Let an edge pass so a following call never re-raises the request in this step
		@(negedge ref_clk);
	endtask : run_cyc
	// Holds the cycle off by one stall source, then lets it go after 300 cycles
	task automatic stall(input int w);
		int n, rd, wr, sy;
		{dma_req, panel_stop, slave_wait} = 3'(1 << w);
		if (w == 2) begin
			need(2, 100, n);
		end
		fork
			begin
				repeat (300) @(negedge ref_clk);
				{dma_req, slave_wait, panel_step} = 3'b001;
				@(negedge ref_clk);
				panel_step = 1'b0;
			end
		join_none
		run_cyc(SMT_MEM_RD, 1'b0, 1000, n, rd, wr, sy);
		chk_bit(n > 300, 1'b1);
		panel_stop = 1'b0;
		@(negedge ref_clk);
	endtask : stall
	// Every cycle kind once, then a blocked write
	task automatic kinds_test;
		int n, rd, wr, sy;
		for (int k = 0; k < 7; k++) begin
			run_cyc(smt_kind_t'(k), 1'b0, 400, n, rd, wr, sy);
			chk_bit(sy > 0, SY[k]);
			chk_byte(seen_status & MSK[k], EXP[k]);
			if (MSK[k] == 8'hFF) begin
				chk_bit(rd > 0, RD[k]);
				chk_bit(wr > 0, WR[k]);
			end
		end
		run_cyc(SMT_MEM_WR, 1'b1, 400, n, rd, wr, sy);
		chk_bit(wr > 0, 1'b0);
	endtask : kinds_test
	task automatic panel_test;
		chk_byte(panel_seen, 8'hA5);
		chk_byte(panel_rx, 8'h3C);
		chk_bit(panel_override, 1'b1);
		panel_data = 8'hC3;
		panel_ddsb = 1'b0;
		// Partner flop, two sync flops and the output flop
		repeat (4) @(negedge ref_clk);
		chk_byte(panel_rx, 8'hC3);
		chk_bit(panel_override, 1'b0);
	endtask : panel_test
	task automatic tick_test;
		int n;
		need(4, 100, n);
		wait_ev(4, 100, n);
		chk_bit(n == T50, 1'b1);
		need(3, 2100, n);
		chk_bit(int5_req, 1'b0);
		tick5_jumper = 1'b1;
		wait_ev(3, 2100, n);
		chk_bit(n == 50 * T50, 1'b1);
		chk_bit(int5_req, 1'b1);
	endtask : tick_test
	task automatic hang_test;
		int n;
		rom_clear = 1'b1;
		@(negedge ref_clk);
		rom_clear = 1'b0;
		@(negedge ref_clk);
		chk_bit(rom_enable, 1'b0);
		int_pending = 1'b1;
		wait_ev(1, 2100, n);
		chk_bit(n >= 1000 && n <= 2010, 1'b1);
		int_pending = 1'b0;
		@(negedge ref_clk);
		chk_bit(rom_enable, 1'b1);
	endtask : hang_test
	task automatic guard_test;
		int n;
		for (int i = 0; i < 4; i++) begin
			{int_enabled, dma_req, supervisor, panel_wait} = 4'(1 << i);
			int_pending = 1'b1;
			wait_ev(1, 2500, n);
			chk_bit(n > 2500, 1'b1);
			{int_enabled, dma_req, supervisor, panel_wait, int_pending} = 5'h00;
			@(negedge ref_clk);
		end
	endtask : guard_test
	task automatic irq_test;
		int n;
		pin_nmi = 1'b1;
		need(1, 20, n);
		int_req = 1'b1;
		need(5, 20, n);
		{pin_nmi, int_req} = 2'b00;
		repeat (10) @(negedge ref_clk);
		chk_bit(bus_int_req, 1'b0);
	endtask : irq_test
	// Jumpers only change under reset; the read is taken at the first PHI rise
	task automatic phase_cyc(input logic slow, input logic [1:0] sel);
		int n, rd, wr, sy;
		rst_n = 1'b0;
		alt_slow = slow;
		stval_sel = sel;
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		run_cyc(SMT_MEM_RD, 1'b0, 400, n, rd, wr, sy);
		chk_bit(n == 5 * (slow ? PHI_HALF_SLOW : PHI_HALF_FAST), 1'b1);
		chk_bit(rd > 0, 1'b1);
	endtask : phase_cyc
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		kinds_test();
		panel_test();
		stall(0);
		stall(1);
		stall(2);
		tick_test();
		hang_test();
		guard_test();
		irq_test();
		phase_cyc(1'b1, 2'h0);
		phase_cyc(1'b0, 2'h2);
		phase_cyc(1'b1, 2'h3);
		end_of_test();
	end
endmodule : s100_master_timing_bench
